/* src/pirout_pkg.sv */
// package for the pci interrupt routing block
// assumes a single 20 MHz core clock and active-low async reset
package pirout_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_LINES    = 8;
  localparam int unsigned NUM_LEGACY   = 16;
  localparam int unsigned NUM_ADVANCED = 24;
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned SYNC_DEPTH   = 3;
  // ---------------------------------------------------------------
  // fixed irq numbers and serial/parallel reset defaults
  // ---------------------------------------------------------------
  localparam logic [IRQ_W-1:0] IRQ_CASCADE   = 4'h2;
  localparam logic [IRQ_W-1:0] IRQ_SERIAL    = 4'h4;
  localparam logic [IRQ_W-1:0] IRQ_PARALLEL  = 4'h7;
  localparam logic [IRQ_W-1:0] IRQ_MOUSE     = 4'hC;
  localparam logic [IRQ_W-1:0] IRQ_DISK_PRI  = 4'hE;
  localparam logic [IRQ_W-1:0] IRQ_DISK_SEC  = 4'hF;
  // irqs a pci request line may be steered to: 3-7, 9-12, 14, 15
  localparam logic [NUM_LEGACY-1:0] STEER_ALLOWED = 16'hDEF8;
  // ---------------------------------------------------------------
  // request line indices
  // ---------------------------------------------------------------
  localparam int unsigned LINE_A = 0;
  localparam int unsigned LINE_B = 1;
  localparam int unsigned LINE_E = 4;
  localparam int unsigned LINE_F = 5;
  localparam int unsigned LINE_G = 6;
  localparam int unsigned LINE_H = 7;
  localparam int unsigned ADV_BASE = 16;
  // ---------------------------------------------------------------
  // routing mode
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PIROUT_LEGACY   = 2'b01,
    PIROUT_ADVANCED = 2'b10
  } pirout_mode_t;
endpackage

/* src/pirout_sync.sv */
// three-stage input synchroniser with agreement filter
// assumes inputs arrive from outside the core clock domain
`timescale 1ns/1ns
module pirout_sync
  import pirout_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output logic      level_o
);
  logic [SYNC_DEPTH-1:0] stage;

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      stage   <= {SYNC_DEPTH{RST_VAL}};
      level_o <= RST_VAL;
    end
    else
    begin
      stage <= {stage[SYNC_DEPTH-2:0], async_i};
      if (stage[SYNC_DEPTH-2] == stage[SYNC_DEPTH-1])
      begin
        level_o <= stage[SYNC_DEPTH-1];
      end
    end
  end
endmodule

/* src/pirout_top.sv */
// pci interrupt routing: request lines to legacy irq or advanced inputs
// assumes board straps and steering selects are static configuration inputs
`timescale 1ns/1ns
module pirout_top
  import pirout_pkg::*;
(
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_b_i,
  input  wire logic                         advanced_mode_i,
  input  wire logic [NUM_LINES-1:0]         pci_request_line_b_i,
  input  wire logic [3:0]                   slot1_int_b_i,
  input  wire logic [3:0]                   slot2_int_b_i,
  input  wire logic                         bus_ctrl_int_b_i,
  input  wire logic                         net_ctrl_int_b_i,
  input  wire logic [NUM_LINES*IRQ_W-1:0]   steer_sel_i,
  input  wire logic                         serial_irq_i,
  input  wire logic                         parallel_irq_i,
  input  wire logic                         mouse_present_i,
  input  wire logic                         disk_present_i,
  input  wire logic [IRQ_W-1:0]             serial_sel_i,
  input  wire logic                         serial_sel_we_i,
  input  wire logic [IRQ_W-1:0]             parallel_sel_i,
  input  wire logic                         parallel_sel_we_i,
  input  wire logic                         mouse_irq_i,
  input  wire logic                         disk_pri_irq_i,
  input  wire logic                         disk_sec_irq_i,
  input  wire logic                         cascade_irq_i,
  input  wire logic                         chan_check_i,
  output logic      [NUM_LEGACY-1:0]        legacy_irq_o,
  output logic      [NUM_ADVANCED-1:0]      advanced_irq_o,
  output logic                              nmi_o,
  output logic      [NUM_LINES-1:0]         line_active_o,
  output logic      [IRQ_W-1:0]             serial_irq_num_o,
  output logic      [IRQ_W-1:0]             parallel_irq_num_o
);
  // ---------------------------------------------------------------
  // board wiring onto request lines (all active low, wired-and)
  // ---------------------------------------------------------------
  logic [NUM_LINES-1:0] wired_b;

  always_comb
  begin
    wired_b = pci_request_line_b_i;
    // slot 1: A,B,C,D -> F,G,H,E ; slot 2: A,B,C,D -> G,F,E,H
    wired_b[LINE_F] = wired_b[LINE_F] & slot1_int_b_i[0] & slot2_int_b_i[1];
    wired_b[LINE_G] = wired_b[LINE_G] & slot1_int_b_i[1] & slot2_int_b_i[0];
    wired_b[LINE_H] = wired_b[LINE_H] & slot1_int_b_i[2] & slot2_int_b_i[3];
    wired_b[LINE_E] = wired_b[LINE_E] & slot1_int_b_i[3] & slot2_int_b_i[2];
    wired_b[LINE_B] = wired_b[LINE_B] & bus_ctrl_int_b_i & net_ctrl_int_b_i;
  end

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [NUM_LINES-1:0] line_b_s;
  logic                 mode_s;
  logic                 chk_s;
  logic [6:0]           dev_s;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++)
    begin : g_line_sync
      pirout_sync #(.RST_VAL(1'b1)) u_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .async_i    (wired_b[gi]),
        .level_o    (line_b_s[gi])
      );
    end
  endgenerate

  pirout_sync #(.RST_VAL(1'b0)) u_mode_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    (advanced_mode_i),
    .level_o    (mode_s)
  );

  pirout_sync #(.RST_VAL(1'b0)) u_chk_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    (chan_check_i),
    .level_o    (chk_s)
  );

  logic [6:0] dev_raw;
  assign dev_raw = {cascade_irq_i, disk_sec_irq_i, disk_pri_irq_i, mouse_irq_i,
                    parallel_irq_i, serial_irq_i, 1'b0};

  generate
    for (gi = 1; gi < 7; gi++)
    begin : g_dev_sync
      pirout_sync #(.RST_VAL(1'b0)) u_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .async_i    (dev_raw[gi]),
        .level_o    (dev_s[gi])
      );
    end
  endgenerate
  assign dev_s[0] = 1'b0;

  // ---------------------------------------------------------------
  // mode
  // ---------------------------------------------------------------
  pirout_mode_t mode;
  assign mode = mode_s ? PIROUT_ADVANCED : PIROUT_LEGACY;

  // active-high level per request line
  wire [NUM_LINES-1:0] line_act = ~line_b_s;

  // ---------------------------------------------------------------
  // reprogrammable serial/parallel irq numbers
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] serial_num;
  logic [IRQ_W-1:0] parallel_num;
  wire serial_ok   = serial_sel_we_i & STEER_ALLOWED[serial_sel_i];
  wire parallel_ok = parallel_sel_we_i & STEER_ALLOWED[parallel_sel_i];

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      serial_num   <= IRQ_SERIAL;
      parallel_num <= IRQ_PARALLEL;
    end
    else
    begin
      if (serial_ok)
      begin
        serial_num <= serial_sel_i;
      end
      if (parallel_ok)
      begin
        parallel_num <= parallel_sel_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // legacy irq assembly
  // ---------------------------------------------------------------
  logic [NUM_LEGACY-1:0] next_legacy;
  logic [NUM_LEGACY-1:0] fixed_map;
  logic [NUM_LEGACY-1:0] steer_map;

  always_comb
  begin
    fixed_map = '0;
    fixed_map[IRQ_CASCADE] = dev_s[6];
    fixed_map[serial_num] = fixed_map[serial_num] | dev_s[1];
    fixed_map[parallel_num] = fixed_map[parallel_num] | dev_s[2];
    if (mouse_present_i)
    begin
      fixed_map[IRQ_MOUSE] = fixed_map[IRQ_MOUSE] | dev_s[3];
    end
    if (disk_present_i)
    begin
      fixed_map[IRQ_DISK_PRI] = fixed_map[IRQ_DISK_PRI] | dev_s[4];
      fixed_map[IRQ_DISK_SEC] = fixed_map[IRQ_DISK_SEC] | dev_s[5];
    end
    steer_map = '0;
    for (int i = 0; i < NUM_LINES; i++)
    begin
      // unassignable numbers (incl. cascade) drop the line
      if (STEER_ALLOWED[steer_sel_i[i*IRQ_W +: IRQ_W]])
      begin
        steer_map[steer_sel_i[i*IRQ_W +: IRQ_W]] =
          steer_map[steer_sel_i[i*IRQ_W +: IRQ_W]] | line_act[i];
      end
    end
    if (mode == PIROUT_LEGACY)
    begin
      next_legacy = fixed_map | steer_map;
    end
    else
    begin
      next_legacy = fixed_map;
    end
  end

  // ---------------------------------------------------------------
  // advanced inputs
  // ---------------------------------------------------------------
  logic [NUM_ADVANCED-1:0] next_advanced;
  always_comb
  begin
    next_advanced = '0;
    if (mode == PIROUT_ADVANCED)
    begin
      next_advanced[NUM_LEGACY-1:0] = fixed_map;
      next_advanced[NUM_ADVANCED-1:ADV_BASE] = line_act;
    end
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      legacy_irq_o       <= '0;
      advanced_irq_o     <= '0;
      nmi_o              <= 1'b0;
      line_active_o      <= '0;
      serial_irq_num_o   <= IRQ_SERIAL;
      parallel_irq_num_o <= IRQ_PARALLEL;
    end
    else
    begin
      legacy_irq_o       <= next_legacy;
      advanced_irq_o     <= next_advanced;
      nmi_o              <= chk_s;
      line_active_o      <= line_act;
      serial_irq_num_o   <= serial_num;
      parallel_irq_num_o <= parallel_num;
    end
  end

  // ---------------------------------------------------------------
  // cycles since reset, for checks that look back over the inputs
  // ---------------------------------------------------------------
  localparam logic [2:0] SETTLE_DONE = 3'h7;
  logic [2:0]            since_rst;

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      since_rst <= '0;
    end
    else if (since_rst != SETTLE_DONE)
    begin
      since_rst <= since_rst + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_legacy_no_advanced: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (mode == PIROUT_LEGACY) |=> (advanced_irq_o == '0))
    else $error("advanced inputs active in legacy mode");

  chk_advanced_line_map: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (mode == PIROUT_ADVANCED) |=> (advanced_irq_o[NUM_ADVANCED-1:ADV_BASE] == $past(line_act)))
    else $error("advanced inputs 16-23 do not follow lines A-H");

  chk_advanced_low_fixed: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (mode == PIROUT_ADVANCED) |=> (advanced_irq_o[NUM_LEGACY-1:0] == $past(fixed_map)))
    else $error("advanced low inputs wrong");

  chk_cascade_reserved: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !$past(dev_s[6]) |-> !legacy_irq_o[IRQ_CASCADE])
    else $error("irq 2 raised without cascade");

  chk_slot_rotation: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (since_rst == SETTLE_DONE && !slot1_int_b_i[0]
      && slot1_int_b_i[0] == $past(slot1_int_b_i[0], 6))
      |-> (line_active_o[LINE_F]))
    else $error("slot 1 pin A not on line F");

  chk_shared_line_b: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (since_rst == SETTLE_DONE && !net_ctrl_int_b_i
      && !net_ctrl_int_b_i == !$past(net_ctrl_int_b_i, 6))
      |-> line_active_o[LINE_B])
    else $error("network controller not on line B");

  chk_nmi_follows: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(chk_s) |=> nmi_o)
    else $error("nmi not raised on channel check");

  chk_nmi_clears: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $fell(chk_s) |=> !nmi_o)
    else $error("nmi not cleared after channel check");

  chk_serial_default: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!$past(serial_ok) && $past(serial_num) == IRQ_SERIAL) |-> serial_num == IRQ_SERIAL)
    else $error("serial irq changed without write");

  chk_steer_legacy: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (mode == PIROUT_LEGACY && line_act[0]
      && STEER_ALLOWED[steer_sel_i[IRQ_W-1:0]]) |=> legacy_irq_o[$past(steer_sel_i[IRQ_W-1:0])])
    else $error("line A not steered to its irq");
endmodule

/* sim/pirout_cards.sv */
// far-side model: add-in cards in two slots and on-board pci sources
// assumes the bench holds each request level until the next settle point
`timescale 1ns/1ns
module pirout_cards
(
  input  wire logic [7:0] board_req_i,
  input  wire logic [3:0] slot1_req_i,
  input  wire logic [3:0] slot2_req_i,
  input  wire logic [2:0] slot1_cnt_i,
  input  wire logic [2:0] slot2_cnt_i,
  input  wire logic       bus_req_i,
  input  wire logic       net_req_i,
  output logic      [7:0] line_b_o,
  output logic      [3:0] slot1_int_b_o,
  output logic      [3:0] slot2_int_b_o,
  output logic            bus_int_b_o,
  output logic            net_int_b_o
);
  // ---------------------------------------------------------------
  // pin use: a card with n interrupts uses pins a upward
  // ---------------------------------------------------------------
  wire logic [3:0] slot1_used = 4'hF >> (3'h4 - slot1_cnt_i);
  wire logic [3:0] slot2_used = 4'hF >> (3'h4 - slot2_cnt_i);
  // unused pins stay released at the pulled-up level
  assign slot1_int_b_o = ~(slot1_req_i & slot1_used);
  assign slot2_int_b_o = ~(slot2_req_i & slot2_used);
  assign line_b_o      = ~board_req_i;
  assign bus_int_b_o   = ~bus_req_i;
  assign net_int_b_o   = ~net_req_i;
endmodule

/* sim/pirout_top_test.sv */
// self-checking bench for the pci interrupt routing block
// assumes pirout_pkg and the cards model are compiled first
`timescale 1ns/1ns
module pirout_top_test;
  import pirout_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        core_clk_i = 1'b0;
  logic        rst_b_i    = 1'b0;
  logic        adv        = 1'b0;
  logic [7:0]  board_req  = 8'h00;
  logic [3:0]  s1_req     = 4'h0;
  logic [3:0]  s2_req     = 4'h0;
  logic [2:0]  s1_cnt     = 3'h0;
  logic [2:0]  s2_cnt     = 3'h0;
  logic        bus_req    = 1'b0;
  logic        net_req    = 1'b0;
  logic [31:0] steer      = 32'h0;
  logic [8:0]  src        = 9'h000;
  logic [3:0]  sel        = 4'h0;
  logic        ser_we     = 1'b0;
  logic        par_we     = 1'b0;
  logic [3:0]  exp_ser    = IRQ_SERIAL;
  logic [3:0]  exp_par    = IRQ_PARALLEL;
  wire logic [7:0]  line_b, line_act;
  wire logic [3:0]  s1_b, s2_b, ser_num, par_num;
  wire logic        bus_b, net_b, nmi;
  wire logic [15:0] leg;
  wire logic [23:0] advo;
  int          bad_count  = 0;
  int          tests_run  = 0;
  logic [3:0]  picks [16] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB,
                              4'hC, 4'hE, 4'hF, 4'h0, 4'h1, 4'h2, 4'h8, 4'hD};
  int          s2_map [4] = '{6, 5, 4, 7};
  always #25 core_clk_i = ~core_clk_i;
  pirout_cards i_cards (.board_req_i(board_req), .slot1_req_i(s1_req), .slot2_req_i(s2_req),
    .slot1_cnt_i(s1_cnt), .slot2_cnt_i(s2_cnt), .bus_req_i(bus_req), .net_req_i(net_req),
    .line_b_o(line_b), .slot1_int_b_o(s1_b), .slot2_int_b_o(s2_b), .bus_int_b_o(bus_b),
    .net_int_b_o(net_b));
  pirout_top i_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .advanced_mode_i(adv),
    .pci_request_line_b_i(line_b), .slot1_int_b_i(s1_b), .slot2_int_b_i(s2_b),
    .bus_ctrl_int_b_i(bus_b), .net_ctrl_int_b_i(net_b), .steer_sel_i(steer),
    .serial_irq_i(src[0]), .parallel_irq_i(src[1]), .mouse_present_i(src[7]),
    .disk_present_i(src[8]), .serial_sel_i(sel), .serial_sel_we_i(ser_we),
    .parallel_sel_i(sel), .parallel_sel_we_i(par_we), .mouse_irq_i(src[2]),
    .disk_pri_irq_i(src[3]), .disk_sec_irq_i(src[4]), .cascade_irq_i(src[5]),
    .chan_check_i(src[6]), .legacy_irq_o(leg), .advanced_irq_o(advo), .nmi_o(nmi),
    .line_active_o(line_act), .serial_irq_num_o(ser_num), .parallel_irq_num_o(par_num));
  // ---------------------------------------------------------------
  // expected values
  // ---------------------------------------------------------------
  function automatic logic [7:0] exp_lines();
    logic [7:0] l;
    l = board_req;
    for (int p = 0; p < 4; p++)
    begin
      if (s1_req[p] && p < s1_cnt) l[(p + 1) % 4 + 4] = 1'b1;
      if (s2_req[p] && p < s2_cnt) l[s2_map[p]] = 1'b1;
    end
    l[LINE_B] = l[LINE_B] | bus_req | net_req;
    return l;
  endfunction
  function automatic logic [15:0] exp_fixed();
    logic [15:0] f;
    f = 16'h0000;
    f[exp_ser] = src[0];
    f[exp_par] = f[exp_par] | src[1];
    f[IRQ_MOUSE] = f[IRQ_MOUSE] | (src[2] & src[7]);
    f[IRQ_DISK_PRI] = f[IRQ_DISK_PRI] | (src[3] & src[8]);
    f[IRQ_DISK_SEC] = f[IRQ_DISK_SEC] | (src[4] & src[8]);
    f[IRQ_CASCADE] = f[IRQ_CASCADE] | src[5];
    return f;
  endfunction
  function automatic logic [15:0] exp_legacy();
    logic [15:0] f;
    logic [7:0]  l;
    f = exp_fixed();
    l = exp_lines();
    for (int i = 0; i < 8; i++)
      if (!adv && l[i] && STEER_ALLOWED[steer[4*i +: 4]]) f[steer[4*i +: 4]] = 1'b1;
    return f;
  endfunction
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] want, input string what);
    tests_run++;
    if (seen !== want)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge core_clk_i);
    #5;
    check(24'(line_act), 24'(exp_lines()), "lines");
    check(24'(leg), 24'(exp_legacy()), "legacy");
    check(advo, adv ? {exp_lines(), exp_fixed()} : 24'h0, "advanced");
    check(24'(nmi), 24'(src[6]), "nmi");
    check(24'({ser_num, par_num}), 24'({exp_ser, exp_par}), "port irqs");
  endtask
  task automatic prog(input logic par, input logic [3:0] v);
    sel = v;
    ser_we = !par;
    par_we = par;
    @(posedge core_clk_i);
    #5;
    ser_we = 1'b0;
    par_we = 1'b0;
    if (STEER_ALLOWED[v] && par) exp_par = v;
    if (STEER_ALLOWED[v] && !par) exp_ser = v;
    @(posedge core_clk_i);
    #5;
  endtask
  task automatic shuffle();
    board_req = 8'($urandom);
    {s1_req, s2_req} = 8'($urandom);
    s1_cnt = 3'($urandom_range(4));
    s2_cnt = 3'($urandom_range(4));
    {bus_req, net_req} = 2'($urandom);
    src = 9'($urandom);
    if (adv) src[5] = 1'b0;
    for (int i = 0; i < 8; i++) steer[4*i +: 4] = picks[$urandom_range(15)];
  endtask
  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h1124AB40));
    repeat (5) @(posedge core_clk_i);
    #5;
    rst_b_i = 1'b1;
    settle();
    steer = {8{4'h9}};
    board_req = 8'h80;
    settle();
    prog(1'b0, 4'h2);
    prog(1'b0, 4'hA);
    prog(1'b1, 4'h8);
    prog(1'b1, 4'h5);
    src = 9'h023;
    settle();
    for (int n = 0; n < 90; n++)
    begin
      adv = (n >= 60);
      if (n % 5 == 0) prog(n % 10 == 0, picks[$urandom_range(15)]);
      shuffle();
      settle();
    end
    adv = 1'b0;
    rst_b_i = 1'b0;
    exp_ser = IRQ_SERIAL;
    exp_par = IRQ_PARALLEL;
    repeat (2) @(posedge core_clk_i);
    #5;
    rst_b_i = 1'b1;
    settle();
    finish_test();
  end
  initial
  begin
    repeat (4000) @(posedge core_clk_i);
    bad_count++;
    finish_test();
  end
endmodule
